// file: verilog/tfm_defines.svh
// Purpose: constants for the timer interrupt flag and mask block
// Assumes: index registers at byte address index*4 on a 32-bit bus
// Notes: flag and enable bytes share one bit layout
//
// Functional notes
// - unit-3 enable byte at index 0x71 holds capture bit 5, cmp B bit 2, cmp A bit 1, ovf bit 0.
// - an event is requested while its flag, its enable and the global enable are all set.
// - bits 7:6 and 4:3 of every enable and flag byte read as zero.
// - both flag bytes place capture at 5, cmp B at 2, cmp A at 1 and overflow at 0.
// - the capture flag sets on a capture event from the unit's capture pin.
// - in modes that use the capture register as top, the capture flag sets at top instead.
// - a compare flag sets in the timer clock cycle after the counter matched its compare value.
// - a forced compare strobe never sets a compare flag.
// - in normal and clear-on-compare modes overflow sets on counter wrap, else by mode.
// - a flag clears when the CPU takes its interrupt vector.
// - software clears a flag by writing a one to its bit.
// - unit-1 enable byte uses the same bit layout, also gated by the global enable.
`ifndef TFM_DEFINES_SVH
`define TFM_DEFINES_SVH
`define TFM_IDX_T1_EN 10'h06F
`define TFM_IDX_T3_EN 10'h071
`define TFM_IDX_T1_FL 10'h036
`define TFM_IDX_T3_FL 10'h038
`define TFM_BIT_CAP 5
`define TFM_BIT_CMPB 2
`define TFM_BIT_CMPA 1
`define TFM_BIT_OVF 0
`define TFM_RST_BYTE 8'h00
`define TFM_RST_EVT 4'h0
`define TFM_WGM_NORMAL 4'h0
`define TFM_WGM_CTC_OCR 4'h4
`define TFM_WGM_CTC_ICR 4'hC
`define TFM_RESP_OKAY 2'h0
`define TFM_RESP_SLVERR 2'h2
`endif

// file: verilog/tfm_pkg.sv
// Purpose: types and shared helpers for the timer interrupt block
// Assumes: tfm_defines.svh on the include path
// Notes: event vector order is {capture, cmp B, cmp A, overflow}
`include "tfm_defines.svh"
package tfm_pkg;
  typedef logic [3:0] tfm_evt_t;
  typedef logic [11:0] tfm_addr_t;
  typedef enum logic [1:0] {TFM_OVF_WRAP, TFM_OVF_TOP, TFM_OVF_BOTTOM} tfm_ovf_src_e;
  typedef enum logic [2:0] {TFM_R_NONE, TFM_R_T1_EN, TFM_R_T3_EN, TFM_R_T1_FL, TFM_R_T3_FL}
    tfm_reg_e;

  // byte layout, same for both units and both register kinds
  function automatic logic [7:0] tfm_expand(input tfm_evt_t e);
    logic [7:0] b;
    b = `TFM_RST_BYTE;
    b[`TFM_BIT_CAP] = e[3];
    b[`TFM_BIT_CMPB] = e[2];
    b[`TFM_BIT_CMPA] = e[1];
    b[`TFM_BIT_OVF] = e[0];
    return b;
  endfunction

  function automatic tfm_evt_t tfm_compact(input logic [7:0] b);
    return {b[`TFM_BIT_CAP], b[`TFM_BIT_CMPB], b[`TFM_BIT_CMPA], b[`TFM_BIT_OVF]};
  endfunction

  function automatic logic tfm_icr_top(input logic [3:0] m);
    return (m == 4'h8) || (m == 4'hA) || (m == `TFM_WGM_CTC_ICR) || (m == 4'hE);
  endfunction

  function automatic tfm_ovf_src_e tfm_ovf_src(input logic [3:0] m);
    if (m == `TFM_WGM_NORMAL || m == `TFM_WGM_CTC_OCR || m == `TFM_WGM_CTC_ICR) begin
      return TFM_OVF_WRAP;
    end else if (m == 4'h5 || m == 4'h6 || m == 4'h7 || m == 4'hE || m == 4'hF) begin
      return TFM_OVF_TOP;
    end
    return TFM_OVF_BOTTOM;
  endfunction

  function automatic tfm_reg_e tfm_decode(input tfm_addr_t a);
    if (a[1:0] != 2'h0) begin
      return TFM_R_NONE;
    end
    unique case (a[11:2])
      `TFM_IDX_T1_EN: return TFM_R_T1_EN;
      `TFM_IDX_T3_EN: return TFM_R_T3_EN;
      `TFM_IDX_T1_FL: return TFM_R_T1_FL;
      `TFM_IDX_T3_FL: return TFM_R_T3_FL;
      default: return TFM_R_NONE;
    endcase
  endfunction
endpackage

// file: verilog/tfm_evt.sv
// Purpose: turn one timer core's raw strobes into flag set pulses
// Assumes: strobes are one aclk wide and synchronous to aclk
// Notes: set pulses are registered: capture and overflow one aclk after their cause, compare one aclk after the next tick
`timescale 1ns/100ps
module tfm_evt (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic timer_tick,
  input wire logic [3:0] waveform_mode_bits,
  input wire logic capture_event,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic overflow_event,
  input wire logic cmp_a_match,
  input wire logic cmp_b_match,
  output tfm_pkg::tfm_evt_t set_evt
);
  import tfm_pkg::*;

  logic [1:0] seen;
  logic [1:0] next_seen;
  tfm_evt_t next_set_evt;
  logic ovf_hit;

  always_comb begin
    next_seen = seen;
    next_set_evt = `TFM_RST_EVT;
    ovf_hit = 1'b0;
    // match noted on one timer tick, flag raised on the next one
    if (timer_tick) begin
      next_seen = {cmp_b_match, cmp_a_match};
      next_set_evt[2:1] = seen;
    end
    // force strobes never enter here, so they cannot raise a compare flag
    next_set_evt[3] = tfm_icr_top(waveform_mode_bits) ? counter_at_top
                                                       : capture_event;
    unique case (tfm_ovf_src(waveform_mode_bits))
      TFM_OVF_WRAP: ovf_hit = overflow_event;
      TFM_OVF_TOP: ovf_hit = counter_at_top;
      TFM_OVF_BOTTOM: ovf_hit = counter_at_bottom;
    endcase
    next_set_evt[0] = ovf_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 2'h0;
      set_evt <= `TFM_RST_EVT;
    end else if (ce) begin
      seen <= next_seen;
      set_evt <= next_set_evt;
    end
  end
endmodule

// file: verilog/tfm_flags.sv
// Purpose: one unit's four sticky interrupt flags
// Assumes: set, write-one-clear and vector acks are one aclk pulses
// Notes: a set beats any clear arriving in the same cycle
`timescale 1ns/100ps
module tfm_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input tfm_pkg::tfm_evt_t set_evt,
  input tfm_pkg::tfm_evt_t w1c,
  input tfm_pkg::tfm_evt_t vec_ack,
  output tfm_pkg::tfm_evt_t flags
);
  import tfm_pkg::*;

  tfm_evt_t next_flags;

  always_comb begin
    // zero bits in w1c leave the flag as it is
    next_flags = (flags & ~(w1c | vec_ack)) | set_evt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `TFM_RST_EVT;
    end else if (ce) begin
      flags <= next_flags;
    end
  end
endmodule

// file: verilog/tfm_irq_top.sv
// Purpose: interrupt flags and enables for two 16-bit timer units
// Assumes: AXI4-Lite master, one write and one read in flight at most
// Notes: index 0 of internal arrays is unit 1, index 1 is unit 3
`timescale 1ns/100ps
module tfm_irq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic global_irq_en,
  input wire logic t1_timer_tick,
  input wire logic [3:0] t1_waveform_mode_bits,
  input wire logic t1_capture_event,
  input wire logic t1_counter_at_top,
  input wire logic t1_counter_at_bottom,
  input wire logic t1_overflow_event,
  input wire logic t1_cmp_a_match,
  input wire logic t1_cmp_b_match,
  input wire logic t1_force_cmp_a,
  input wire logic t1_force_cmp_b,
  input wire logic [3:0] t1_vector_ack,
  input wire logic t3_timer_tick,
  input wire logic [3:0] t3_waveform_mode_bits,
  input wire logic t3_capture_event,
  input wire logic t3_counter_at_top,
  input wire logic t3_counter_at_bottom,
  input wire logic t3_overflow_event,
  input wire logic t3_cmp_a_match,
  input wire logic t3_cmp_b_match,
  input wire logic t3_force_cmp_a,
  input wire logic t3_force_cmp_b,
  input wire logic [3:0] t3_vector_ack,
  output tfm_pkg::tfm_evt_t t1_irq_req,
  output tfm_pkg::tfm_evt_t t3_irq_req,
  input wire logic awvalid,
  output logic awready,
  input tfm_pkg::tfm_addr_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input tfm_pkg::tfm_addr_t araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import tfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // event qualification and flags

  tfm_evt_t set_evt [2];
  tfm_evt_t flags [2];
  tfm_evt_t w1c [2];
  tfm_evt_t en [2];

  tfm_evt tfm_evt_u1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .timer_tick(t1_timer_tick),
    .waveform_mode_bits(t1_waveform_mode_bits),
    .capture_event(t1_capture_event),
    .counter_at_top(t1_counter_at_top),
    .counter_at_bottom(t1_counter_at_bottom),
    .overflow_event(t1_overflow_event),
    .cmp_a_match(t1_cmp_a_match),
    .cmp_b_match(t1_cmp_b_match),
    .set_evt(set_evt[0])
  );

  tfm_evt tfm_evt_u3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .timer_tick(t3_timer_tick),
    .waveform_mode_bits(t3_waveform_mode_bits),
    .capture_event(t3_capture_event),
    .counter_at_top(t3_counter_at_top),
    .counter_at_bottom(t3_counter_at_bottom),
    .overflow_event(t3_overflow_event),
    .cmp_a_match(t3_cmp_a_match),
    .cmp_b_match(t3_cmp_b_match),
    .set_evt(set_evt[1])
  );

  tfm_flags tfm_flags_u1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set_evt(set_evt[0]),
    .w1c(w1c[0]),
    .vec_ack(t1_vector_ack),
    .flags(flags[0])
  );

  tfm_flags tfm_flags_u3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set_evt(set_evt[1]),
    .w1c(w1c[1]),
    .vec_ack(t3_vector_ack),
    .flags(flags[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_held;
  logic w_held;
  tfm_addr_t aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  tfm_reg_e wr_sel;
  logic next_aw_held;
  logic next_w_held;
  tfm_addr_t next_aw_addr;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_awready;
  logic next_wready;
  tfm_evt_t next_en [2];

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_en = en;
    w1c[0] = `TFM_RST_EVT;
    w1c[1] = `TFM_RST_EVT;
    wr_fire = aw_held && w_held && !bvalid;
    wr_sel = tfm_decode(aw_addr);
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_sel == TFM_R_NONE) ? `TFM_RESP_SLVERR : `TFM_RESP_OKAY;
      // only lane 0 carries register bits; other lanes are dropped
      if (w_lane0) begin
        unique case (wr_sel)
          TFM_R_T1_EN: next_en[0] = tfm_compact(w_byte);
          TFM_R_T3_EN: next_en[1] = tfm_compact(w_byte);
          TFM_R_T1_FL: w1c[0] = tfm_compact(w_byte);
          TFM_R_T3_FL: w1c[1] = tfm_compact(w_byte);
          TFM_R_NONE: ;
        endcase
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= `TFM_RST_BYTE;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TFM_RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      en[0] <= `TFM_RST_EVT;
      en[1] <= `TFM_RST_EVT;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      awready <= next_awready;
      wready <= next_wready;
      en <= next_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel and request outputs

  logic next_rvalid;
  logic next_arready;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  tfm_evt_t next_t1_req;
  tfm_evt_t next_t3_req;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = `TFM_RESP_OKAY;
      next_rdata = '0;
      unique case (tfm_decode(araddr))
        TFM_R_T1_EN: next_rdata[7:0] = tfm_expand(en[0]);
        TFM_R_T3_EN: next_rdata[7:0] = tfm_expand(en[1]);
        TFM_R_T1_FL: next_rdata[7:0] = tfm_expand(flags[0]);
        TFM_R_T3_FL: next_rdata[7:0] = tfm_expand(flags[1]);
        TFM_R_NONE: next_rresp = `TFM_RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
    // each enable only counts while the global enable is on
    next_t1_req = flags[0] & en[0] & {4{global_irq_en}};
    next_t3_req = flags[1] & en[1] & {4{global_irq_en}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= '0;
      rresp <= `TFM_RESP_OKAY;
      t1_irq_req <= `TFM_RST_EVT;
      t3_irq_req <= `TFM_RST_EVT;
    end else if (ce) begin
      rvalid <= next_rvalid;
      arready <= next_arready;
      rdata <= next_rdata;
      rresp <= next_rresp;
      t1_irq_req <= next_t1_req;
      t3_irq_req <= next_t3_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_req_gated: assert property (
    t3_irq_req == ($past(flags[1]) & $past(en[1]) & {4{$past(global_irq_en)}}))
    else $error("unit 3 request does not follow flag, enable and global enable");
  a_req_needs_gie: assert property (
    !global_irq_en |=> (t1_irq_req == 4'h0) && (t3_irq_req == 4'h0))
    else $error("request raised while global enable was off");
  a_t1_en_gate: assert property (
    (flags[0][3] && en[0][3] && global_irq_en) |=> t1_irq_req[3])
    else $error("unit 1 capture request missing");
  a_rsvd_zero: assert property (
    rvalid |-> (rdata[7:6] == 2'h0) && (rdata[4:3] == 2'h0))
    else $error("reserved read bits not zero");
  a_flag_layout: assert property (
    (arvalid && arready && tfm_decode(araddr) == TFM_R_T3_FL)
      |=> rdata[5] == $past(flags[1][3]) && rdata[0] == $past(flags[1][0]))
    else $error("flag byte layout wrong");
  a_cap_pin: assert property (
    (!tfm_icr_top(t1_waveform_mode_bits) && t1_capture_event) |-> ##2 flags[0][3])
    else $error("capture event did not set capture flag");
  a_cap_top: assert property (
    (tfm_icr_top(t3_waveform_mode_bits) && t3_counter_at_top) |-> ##2 flags[1][3])
    else $error("top in capture-top mode did not set capture flag");
  a_cmp_next_tick: assert property (
    (t1_timer_tick && t1_cmp_a_match) ##1 (!t1_timer_tick)[*3] ##1 t1_timer_tick
      |-> ##2 flags[0][1])
    else $error("compare flag not set after the following timer tick");
  a_force_no_set: assert property (
    (t1_force_cmp_a && !t1_cmp_a_match && !tfm_evt_u1.seen[0] && !set_evt[0][1]
      && !flags[0][1]) |=> !flags[0][1] ##1 !flags[0][1])
    else $error("forced compare strobe set a compare flag");
  a_ovf_normal: assert property (
    (t1_waveform_mode_bits == `TFM_WGM_NORMAL && t1_overflow_event) |-> ##2 flags[0][0])
    else $error("overflow did not set overflow flag");
  a_vec_clear: assert property (
    (t1_vector_ack[0] && !set_evt[0][0]) |=> !flags[0][0])
    else $error("vector ack did not clear overflow flag");
  a_w1c_clear: assert property (
    (w1c[1][2] && !set_evt[1][2]) |=> !flags[1][2])
    else $error("write one did not clear compare B flag");
  a_set_wins: assert property (
    ((set_evt[1] & (w1c[1] | t3_vector_ack)) != 4'h0)
      |=> (flags[1] & $past(set_evt[1])) == $past(set_evt[1]))
    else $error("clear beat a set in the same cycle");
  a_reset_zero: assert property (
    $rose(aresetn) |-> (flags[0] == 4'h0) && (flags[1] == 4'h0)
      && (en[0] == 4'h0) && (en[1] == 4'h0))
    else $error("flags or enables not zero after reset");

  c_t1_cmp_req: cover property (t1_irq_req[1]);
  c_t3_cap_req: cover property (t3_irq_req[3]);
  c_write_resp: cover property (bvalid && bready);
  c_set_vs_clear: cover property (set_evt[1][3] && w1c[1][3]);
endmodule

// file: tb/tfm_partner.sv
// Purpose: cpu vector logic and timer clock divider facing one timer unit
// Assumes: irq_req is a registered level from the block
// Notes: lowest pending vector first; ack_dly makes the cpu slow or prompt
`timescale 1ns/100ps
module tfm_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  input tfm_pkg::tfm_evt_t irq_req,
  output logic tick,
  output tfm_pkg::tfm_evt_t vector_ack
);
  import tfm_pkg::*;
  logic [1:0] div;
  logic [3:0] cnt;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 2'h0;
      tick <= 1'b0;
      cnt <= 4'h0;
      vector_ack <= 4'h0;
    end else begin
      div <= div + 2'h1;
      // timer clock at a quarter of aclk
      tick <= div == 2'h3;
      vector_ack <= 4'h0;
      // no ack right after one: the level takes two cycles to fall
      if (!ack_en || irq_req == 4'h0 || vector_ack != 4'h0) begin
        cnt <= 4'h0;
      end else if (cnt == ack_dly) begin
        vector_ack <= irq_req & (~irq_req + 4'h1);
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// file: tb/tfm_irq_top_tb.sv
// Purpose: self-checking bench for the timer interrupt flag and enable block
// Assumes: axi4-lite master tasks below, one cpu partner per unit
// Notes: int model of flags and enables, compared at every read
`timescale 1ns/100ps
`include "tfm_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tfm_irq_top_tb;
  import tfm_pkg::*;
  localparam tfm_addr_t a_en [2] = '{{`TFM_IDX_T1_EN, 2'h0}, {`TFM_IDX_T3_EN, 2'h0}};
  localparam tfm_addr_t a_fl [2] = '{{`TFM_IDX_T1_FL, 2'h0}, {`TFM_IDX_T3_FL, 2'h0}};
  // mode, strobes {fb,fa,mb,ma,ovf,bot,top,cap}, flags expected
  localparam logic [3:0] tm [11] = '{4'h0, 4'h0, 4'h4, 4'hC, 4'h0, 4'h0, 4'hC, 4'h8, 4'h5,
    4'hE, 4'h4};
  localparam logic [7:0] ts [11] = '{8'h01, 8'h08, 8'h08, 8'h08, 8'hC0, 8'h06, 8'h02, 8'h06,
    8'h02, 8'h02, 8'h06};
  localparam int tf [11] = '{32'h20, 32'h01, 32'h01, 32'h01, 32'h00, 32'h00, 32'h20, 32'h21,
    32'h01, 32'h21, 32'h00};
  logic aclk, aresetn, ce, gie;
  logic [7:0] strb [2];
  logic [3:0] wgm [2];
  logic tick [2];
  logic ack_en [2];
  logic [3:0] ack_dly [2];
  tfm_evt_t vack [2];
  tfm_evt_t req [2];
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  tfm_addr_t awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_fail, n_tests;
  int mfl [2];
  int men [2];
  //////////////////////////////////////////////////////////////////////////////
  tfm_irq_top u_tfm_irq_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .global_irq_en(gie),
    .t1_timer_tick(tick[0]), .t1_waveform_mode_bits(wgm[0]),
    .t1_capture_event(strb[0][0]), .t1_counter_at_top(strb[0][1]),
    .t1_counter_at_bottom(strb[0][2]), .t1_overflow_event(strb[0][3]),
    .t1_cmp_a_match(strb[0][4]), .t1_cmp_b_match(strb[0][5]),
    .t1_force_cmp_a(strb[0][6]), .t1_force_cmp_b(strb[0][7]),
    .t1_vector_ack(vack[0]), .t1_irq_req(req[0]),
    .t3_timer_tick(tick[1]), .t3_waveform_mode_bits(wgm[1]),
    .t3_capture_event(strb[1][0]), .t3_counter_at_top(strb[1][1]),
    .t3_counter_at_bottom(strb[1][2]), .t3_overflow_event(strb[1][3]),
    .t3_cmp_a_match(strb[1][4]), .t3_cmp_b_match(strb[1][5]),
    .t3_force_cmp_a(strb[1][6]), .t3_force_cmp_b(strb[1][7]),
    .t3_vector_ack(vack[1]), .t3_irq_req(req[1]),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );
  for (genvar g = 0; g < 2; g++) begin : g_cpu
    tfm_partner u_tfm_partner (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en[g]),
      .ack_dly(ack_dly[g]), .irq_req(req[g]), .tick(tick[g]), .vector_ack(vack[g]));
  end
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic tfm_evt_t exp_req(int u);
    int b;
    b = gie ? mfl[u] & men[u] : 0;
    return {b[5], b[2], b[1], b[0]};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tmo(int i);
    if (i >= 40) begin
      n_fail++;
      results();
    end
  endtask
  task automatic axi_wr(input tfm_addr_t a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(i);
  endtask
  task automatic axi_rd(input tfm_addr_t a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(i);
  endtask
  task automatic rd_chk(input tfm_addr_t a, input int e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(d, e[31:0])
    `CHK(r, er)
    `CHK(req[0], exp_req(0))
    `CHK(req[1], exp_req(1))
  endtask
  task automatic wr_reg(input tfm_addr_t a, input logic [31:0] v, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, v, r);
    `CHK(r, er)
  endtask
  task automatic wr_en(int u, logic [31:0] v);
    wr_reg(a_en[u], v, `TFM_RESP_OKAY);
    men[u] = int'(v & 32'h27);
  endtask
  task automatic wr_fl(int u, logic [31:0] v);
    wr_reg(a_fl[u], v, `TFM_RESP_OKAY);
    mfl[u] &= ~int'(v);
  endtask
  task automatic pulse(int u, logic [7:0] m);
    @(posedge aclk);
    strb[u] <= m;
    @(posedge aclk);
    strb[u] <= 8'h00;
    repeat (4) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int u, i;
    logic [31:0] v;
    logic [1:0] r;
    {aresetn, gie, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    seed = 32'hCDB4;
    n_fail = 0;
    n_tests = 0;
    for (u = 0; u < 2; u++) begin
      {strb[u], wgm[u], ack_en[u], mfl[u], men[u]} = '0;
      ack_dly[u] = 4'h3;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (u = 0; u < 2; u++) begin
      rd_chk(a_en[u], 0, `TFM_RESP_OKAY);
      rd_chk(a_fl[u], 0, `TFM_RESP_OKAY);
    end
    rd_chk(12'h1C0, 0, `TFM_RESP_SLVERR);
    wr_reg(12'h1C0, 32'hFF, `TFM_RESP_SLVERR);
    // random enable bytes, global enable toggled alongside
    repeat (8) begin
      u = int'(xs() & 32'h1);
      v = xs();
      gie <= v[8];
      wr_en(u, v);
      rd_chk(a_en[u], men[u], `TFM_RESP_OKAY);
    end
    // lane 0 strobe off: the write must not land
    wstrb <= 4'hE;
    wr_reg(a_en[0], ~men[0], `TFM_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(a_en[0], men[0], `TFM_RESP_OKAY);
    gie <= 1'b1;
    wr_en(0, 32'hFF);
    wr_en(1, 32'hFF);
    for (i = 0; i < 11; i++) begin
      for (u = 0; u < 2; u++) begin
        wgm[u] <= tm[i];
        pulse(u, ts[i]);
        mfl[u] |= tf[i];
        rd_chk(a_fl[u], mfl[u], `TFM_RESP_OKAY);
        wr_fl(u, 32'hFF);
      end
    end
    rd_chk(a_fl[1], 0, `TFM_RESP_OKAY);
    // capture event lands in the same cycle as a clearing write
    @(posedge aclk);
    fork
      axi_wr(a_fl[1], 32'h20, r);
      begin
        @(posedge aclk);
        strb[1] <= 8'h01;
        @(posedge aclk);
        strb[1] <= 8'h00;
      end
    join
    `CHK(r, `TFM_RESP_OKAY)
    mfl[1] = 32'h20;
    rd_chk(a_fl[1], mfl[1], `TFM_RESP_OKAY);
    wr_fl(1, 32'h00);
    rd_chk(a_fl[1], mfl[1], `TFM_RESP_OKAY);
    wr_fl(1, 32'hFF);
    // compare match on one tick, flag only after the next tick
    wgm[0] <= 4'h0;
    wgm[1] <= 4'h0;
    for (u = 0; u < 2; u++) begin
      for (int k = 4; k < 6; k++) begin
        for (i = 0; i < 40; i++) begin
          @(posedge aclk);
          if (tick[u] === 1'b1) break;
        end
        tmo(i);
        strb[u] <= 8'h01 << k;
        repeat (4) @(posedge aclk);
        strb[u] <= 8'h00;
        repeat (4) @(posedge aclk);
        #1;
        `CHK(req[u][k - 3], 1'b0)
        repeat (4) @(posedge aclk);
        #1;
        `CHK(req[u][k - 3], 1'b1)
        mfl[u] |= 1 << (k - 3);
        rd_chk(a_fl[u], mfl[u], `TFM_RESP_OKAY);
        wr_fl(u, 32'hFF);
      end
    end
    // pending with global enable off, then the cpu takes vectors
    gie <= 1'b0;
    pulse(0, 8'h09);
    pulse(1, 8'h09);
    mfl[0] = 32'h21;
    mfl[1] = 32'h21;
    wr_en(1, 32'h01);
    rd_chk(a_fl[0], mfl[0], `TFM_RESP_OKAY);
    for (u = 0; u < 2; u++) begin
      ack_en[u] <= 1'b1;
      ack_dly[u] <= 4'(3 + xs() % 5);
    end
    gie <= 1'b1;
    repeat (60) @(posedge aclk);
    mfl[0] = 0;
    mfl[1] = 32'h20;
    rd_chk(a_fl[0], mfl[0], `TFM_RESP_OKAY);
    rd_chk(a_fl[1], mfl[1], `TFM_RESP_OKAY);
    results();
  end
endmodule
